// ==== design/ppo_pkg.sv ====
// Purpose: Constants for the pulse pattern output block
// Assumes: Classic Wishbone, 32-bit data, word-aligned registers
// Notes:   Register offsets are byte addresses
package ppo_pkg;
    localparam int          PPO_AW            = 6;
    localparam int          PPO_GROUPS        = 4;
    localparam int          PPO_PINS          = 16;
    localparam int          PPO_TIMER_CH      = 4;
    localparam logic [5:0]  PPO_OFF_NDE_HIGH  = 6'h00;
    localparam logic [5:0]  PPO_OFF_NDE_LOW   = 6'h04;
    localparam logic [5:0]  PPO_OFF_OD_HIGH   = 6'h08;
    localparam logic [5:0]  PPO_OFF_OD_LOW    = 6'h0C;
    localparam logic [5:0]  PPO_OFF_NV_HIGH   = 6'h10;
    localparam logic [5:0]  PPO_OFF_NV_LOW    = 6'h14;
    localparam logic [5:0]  PPO_OFF_TRIG_SEL  = 6'h18;
    localparam logic [5:0]  PPO_OFF_MODE      = 6'h1C;
    localparam logic [5:0]  PPO_OFF_NV_G3     = 6'h20;
    localparam logic [5:0]  PPO_OFF_NV_G2     = 6'h24;
    localparam logic [5:0]  PPO_OFF_NV_G1     = 6'h28;
    localparam logic [5:0]  PPO_OFF_NV_G0     = 6'h2C;
    localparam int          PPO_MODE_SPLIT_HI = 0;
    localparam int          PPO_MODE_SPLIT_LO = 1;
    localparam int          PPO_MODE_STOP     = 2;
    localparam logic [7:0]  PPO_RST_BYTE      = 8'h00;
    localparam logic [7:0]  PPO_RST_TRIG_SEL  = 8'hFF;
    localparam logic [2:0]  PPO_RST_MODE      = 3'h0;
    localparam logic [3:0]  PPO_RSVD_NIBBLE   = 4'hF;
endpackage : ppo_pkg

// ==== design/ppo_top.sv ====
// Purpose: Sixteen pulse outputs in four 4-bit groups, updated on timer compare match
// Assumes: Classic Wishbone slave, one wait state, ack one cycle after request
// Notes:   Trigger inputs are one-cycle pulses synchronous to clk_i
`timescale 1ns/100ps
// What this block does
// - Sixteen outputs form four independent four-bit groups that may run together.
// - Triggers come from compare matches of a sixteen-bit timer time base.
// - Pins 15-12 group 3, 11-8 group 2, 7-4 group 1, 3-0 group 0.
// - Enabled upper-byte bits copy next value into output data on trigger.
// - Enabled lower-byte bits copy next value into output data on trigger.
// - Disabled bits keep output data unchanged when a trigger occurs.
// - Software writes to output data bits are ignored while enabled.
// - Software may write output data bits while their enable is clear.
// - All sixteen enable bits reset to zero.
// - Output data resets to zero; enable and data readable and writable.
// - A module stop state halts the pulse generator.
// - A transfer engine may reload next values, driven by timer events.
// - Each group has a two-bit trigger select, channels 0 to 3, reset 11.
// - Split next-value nibble addresses read the unused nibble as ones.
module ppo_top (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ce_i,
    input  wire logic [ppo_pkg::PPO_AW-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    input  wire logic                      wb_we_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic                           wb_ack_o,
    input  wire logic [3:0]                timer_match_i,
    input  wire logic                      module_stop_i,
    output logic      [15:0]               pulse_out_o,
    output logic                           halted_o
);
    logic [15:0] enable_q;
    logic [15:0] out_data_q;
    logic [15:0] next_val_q;
    logic [7:0]  trig_sel_q;
    logic [2:0]  mode_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        access;
    logic        wr;
    logic        stopped;
    logic        wr_nde_high;
    logic        wr_nde_low;
    logic        wr_trig_sel;
    logic        wr_mode;
    logic [15:0] out_data_d;
    logic [15:0] wr_mask;
    logic [15:0] wr_data;
    logic [15:0] nv_mask;
    logic [15:0] nv_data;

    assign access   = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr       = access & wb_we_i & wb_sel_i[0];
    assign stopped  = module_stop_i | mode_q[ppo_pkg::PPO_MODE_STOP];
    assign halted_o = stopped;

    // Decoded write strobes for the plain byte registers
    assign wr_nde_high = wr && (wb_adr_i == ppo_pkg::PPO_OFF_NDE_HIGH);
    assign wr_nde_low  = wr && (wb_adr_i == ppo_pkg::PPO_OFF_NDE_LOW);
    assign wr_trig_sel = wr && (wb_adr_i == ppo_pkg::PPO_OFF_TRIG_SEL);
    assign wr_mode     = wr && (wb_adr_i == ppo_pkg::PPO_OFF_MODE);

    // One slice per group: its trigger pick and its four output data bits
    for (genvar g = 0; g < ppo_pkg::PPO_GROUPS; g++) begin : g_slice
        logic [1:0] sel;
        logic       fire;
        logic [3:0] en;
        logic [3:0] nxt;
        logic [3:0] sw_mask;
        logic [3:0] sw_data;
        logic [3:0] nib_d;

        assign sel     = trig_sel_q[2*g +: 2];
        assign fire    = timer_match_i[sel] & ~stopped;
        assign en      = enable_q[4*g +: 4];
        assign nxt     = next_val_q[4*g +: 4];
        assign sw_mask = wr ? wr_mask[4*g +: 4] : 4'h0;
        assign sw_data = wr_data[4*g +: 4];

        // Enabled bits follow the trigger, disabled bits take software writes
        always_comb begin
            nib_d = out_data_q[4*g +: 4];
            for (int b = 0; b < 4; b++) begin
                if (en[b]) begin
                    if (fire) begin
                        nib_d[b] = nxt[b];
                    end
                end else if (sw_mask[b]) begin
                    nib_d[b] = sw_data[b];
                end
            end
        end

        assign out_data_d[4*g +: 4] = nib_d;
    end

    // Software write lanes into the byte halves of the two 16-bit registers and the nibbles of next value only
    always_comb begin
        wr_mask = 16'h0000;
        wr_data = {wb_dat_i[7:0], wb_dat_i[7:0]};
        nv_mask = 16'h0000;
        nv_data = {wb_dat_i[7:0], wb_dat_i[7:0]};
        case (wb_adr_i)
            ppo_pkg::PPO_OFF_OD_HIGH:  wr_mask = 16'hFF00;
            ppo_pkg::PPO_OFF_OD_LOW:   wr_mask = 16'h00FF;
            ppo_pkg::PPO_OFF_NV_HIGH:  nv_mask = 16'hFF00;
            ppo_pkg::PPO_OFF_NV_LOW:   nv_mask = 16'h00FF;
            ppo_pkg::PPO_OFF_NV_G3:    nv_mask = 16'hF000;
            ppo_pkg::PPO_OFF_NV_G2:    nv_mask = 16'h0F00;
            ppo_pkg::PPO_OFF_NV_G1:    nv_mask = 16'h00F0;
            ppo_pkg::PPO_OFF_NV_G0:    nv_mask = 16'h000F;
            default: begin
                wr_mask = 16'h0000;
                nv_mask = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= {ppo_pkg::PPO_RST_BYTE, ppo_pkg::PPO_RST_BYTE};
        end else if (ce_i) begin
            if (wr_nde_high) begin
                enable_q[15:8] <= wb_dat_i[7:0];
            end
            if (wr_nde_low) begin
                enable_q[7:0] <= wb_dat_i[7:0];
            end
        end
    end

    // Output data: trigger transfer for enabled bits, software write for disabled bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_data_q <= {ppo_pkg::PPO_RST_BYTE, ppo_pkg::PPO_RST_BYTE};
        end else if (ce_i) begin
            out_data_q <= out_data_d;
        end
    end

    // Next values, reloadable by any bus master including a transfer engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            next_val_q <= {ppo_pkg::PPO_RST_BYTE, ppo_pkg::PPO_RST_BYTE};
        end else if (ce_i && wr) begin
            for (int b = 0; b < ppo_pkg::PPO_PINS; b++) begin
                if (nv_mask[b]) begin
                    next_val_q[b] <= nv_data[b];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_sel_q <= ppo_pkg::PPO_RST_TRIG_SEL;
        end else if (ce_i && wr_trig_sel) begin
            trig_sel_q <= wb_dat_i[7:0];
        end
    end

    // Mode: bit 2 halts trigger transfers, split bits are informational
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= ppo_pkg::PPO_RST_MODE;
        end else if (ce_i && wr_mode) begin
            mode_q <= wb_dat_i[2:0];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            ppo_pkg::PPO_OFF_NDE_HIGH: rdata_d[7:0] = enable_q[15:8];
            ppo_pkg::PPO_OFF_NDE_LOW:  rdata_d[7:0] = enable_q[7:0];
            ppo_pkg::PPO_OFF_OD_HIGH:  rdata_d[7:0] = out_data_q[15:8];
            ppo_pkg::PPO_OFF_OD_LOW:   rdata_d[7:0] = out_data_q[7:0];
            ppo_pkg::PPO_OFF_NV_HIGH:  rdata_d[7:0] = next_val_q[15:8];
            ppo_pkg::PPO_OFF_NV_LOW:   rdata_d[7:0] = next_val_q[7:0];
            ppo_pkg::PPO_OFF_TRIG_SEL: rdata_d[7:0] = trig_sel_q;
            ppo_pkg::PPO_OFF_MODE:     rdata_d[2:0] = mode_q;
            ppo_pkg::PPO_OFF_NV_G3:    rdata_d[7:0] = {next_val_q[15:12], ppo_pkg::PPO_RSVD_NIBBLE};
            ppo_pkg::PPO_OFF_NV_G2:    rdata_d[7:0] = {ppo_pkg::PPO_RSVD_NIBBLE, next_val_q[11:8]};
            ppo_pkg::PPO_OFF_NV_G1:    rdata_d[7:0] = {next_val_q[7:4], ppo_pkg::PPO_RSVD_NIBBLE};
            ppo_pkg::PPO_OFF_NV_G0:    rdata_d[7:0] = {ppo_pkg::PPO_RSVD_NIBBLE, next_val_q[3:0]};
            default:                   rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= access;
        end
    end

    // Read data is captured when a request is taken and held until the next one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_i && access) begin
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdata_q;
    assign pulse_out_o = out_data_q;
endmodule : ppo_top

// ==== testbench/ppo_monitor.sv ====
// Purpose: Port checks for ppo_top
// Assumes: ce_i held high in use
// Notes:   Bound to every ppo_top below
`timescale 1ns/100ps
module ppo_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0]  timer_match_i,
    input wire logic        module_stop_i,
    input wire logic [15:0] pulse_out_o,
    input wire logic        halted_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire wr_w = wb_cyc_i && wb_stb_i && wb_we_i;
    wire quiet_w = !(|timer_match_i) && !wr_w;
    sequence s_req;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_follows_req: assert property (s_req |=> s_answer) else $error("ack missing");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000) else $error("high");
    a_stop_halts: assert property (module_stop_i |-> halted_o) else $error("halt low");
    a_out_holds_idle: assert property (quiet_w |=> $stable(pulse_out_o)) else $error("pin moved");
    a_stop_freezes: assert property (module_stop_i && !wr_w |=> $stable(pulse_out_o)) else $error("ran");
    a_reset_clears: assert property (disable iff (1'b0) rst_i && ce_i |=> pulse_out_o == 16'h0000) else $error("rst");
    a_reset_no_ack: assert property (disable iff (1'b0) rst_i && ce_i |=> !wb_ack_o) else $error("rst ack");
endmodule : ppo_monitor
bind ppo_top ppo_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .timer_match_i(timer_match_i),
    .module_stop_i(module_stop_i), .pulse_out_o(pulse_out_o), .halted_o(halted_o));

// ==== testbench/ppo_timer_model.sv ====
// Purpose: Timer time base giving compare match pulses
// Assumes: One-cycle match pulses
// Notes:   Delay sets how slowly a match comes
`timescale 1ns/100ps
module ppo_timer_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    output logic      [3:0] match_o
);
    logic [15:0] count_q;
    initial match_o = 4'h0;
    always_ff @(posedge clk_i) begin
        count_q <= rst_i ? 16'h0000 : count_q + 16'h0001;
    end
    task automatic fire(input int ch, input logic [15:0] dly);
        logic [15:0] cmp;
        cmp = count_q + dly;
        while (count_q != cmp) @(posedge clk_i);
        match_o[ch] <= 1'b1;
        @(posedge clk_i);
        match_o <= 4'h0;
    endtask : fire
endmodule : ppo_timer_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for ppo_top
// Assumes: One-cycle Wishbone answer
// Notes:   Group g listens to timer channel g
`timescale 1ns/100ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        we = 1'b0;
    logic        cs = 1'b0;
    logic        stop = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rd_w;
    logic [15:0] pout_w;
    logic [3:0]  match_w;
    logic        ack_w;
    logic        halt_w;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    initial forever #12.5 clk_i = ~clk_i;
    ppo_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rd_w),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_ack_o(ack_w), .timer_match_i(match_w),
        .module_stop_i(stop), .pulse_out_o(pout_w), .halted_o(halt_w));
    ppo_timer_model i_tmr (.clk_i(clk_i), .rst_i(rst_i), .match_o(match_w));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= {24'h00_0000, d};
        cs <= 1'b1;
        do @(posedge clk_i); while (ack_w !== 1'b1);
        rdat = rd_w;
        cs <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        check(rdat[15:0], {8'h00, e});
    endtask : rd
    task automatic t_reset;
        for (int i = 0; i < 4; i++) rd(ppo_pkg::PPO_OFF_NDE_HIGH + 6'(4 * i), ppo_pkg::PPO_RST_BYTE);
        rd(ppo_pkg::PPO_OFF_TRIG_SEL, ppo_pkg::PPO_RST_TRIG_SEL);
        rd(6'h30, 8'h00);
        bus(ppo_pkg::PPO_OFF_OD_LOW, 1'b1, 8'hA5);
        rd(ppo_pkg::PPO_OFF_OD_LOW, 8'hA5);
        check(pout_w, 16'h00A5);
        $display("t_reset end");
    endtask : t_reset
    task automatic t_trig;
        logic [15:0] exp;
        logic [15:0] m;
        exp = 16'h00A5;
        bus(ppo_pkg::PPO_OFF_TRIG_SEL, 1'b1, 8'hE4);
        bus(ppo_pkg::PPO_OFF_NDE_HIGH, 1'b1, 8'hFF);
        bus(ppo_pkg::PPO_OFF_NDE_LOW, 1'b1, 8'h0F);
        bus(ppo_pkg::PPO_OFF_NV_HIGH, 1'b1, 8'h3C);
        bus(ppo_pkg::PPO_OFF_NV_LOW, 1'b1, 8'h99);
        for (int g = 0; g < 4; g++) begin
            i_tmr.fire(g, 16'(g * 3 + 1));
            @(negedge clk_i);
            m = (16'h000F << (4 * g)) & 16'hFF0F;
            exp = (exp & ~m) | (16'h3C99 & m);
            check(pout_w, exp);
        end
        bus(ppo_pkg::PPO_OFF_OD_LOW, 1'b1, 8'h00);
        rd(ppo_pkg::PPO_OFF_OD_LOW, 8'h09);
        $display("t_trig end");
    endtask : t_trig
    task automatic t_stop;
        @(posedge clk_i) stop <= 1'b1;
        bus(ppo_pkg::PPO_OFF_NV_LOW, 1'b1, 8'h66);
        i_tmr.fire(0, 16'h0001);
        @(negedge clk_i);
        check(pout_w, 16'h3C09);
        check({15'h0000, halt_w}, 16'h0001);
        @(posedge clk_i) stop <= 1'b0;
        i_tmr.fire(0, 16'h0001);
        @(negedge clk_i);
        check(pout_w, 16'h3C06);
        bus(ppo_pkg::PPO_OFF_NV_LOW, 1'b1, 8'h33);
        bus(ppo_pkg::PPO_OFF_MODE, 1'b1, 8'h04);
        rd(ppo_pkg::PPO_OFF_MODE, 8'h04);
        check({15'h0000, halt_w}, 16'h0001);
        i_tmr.fire(0, 16'h0001);
        @(negedge clk_i);
        check(pout_w, 16'h3C06);
        bus(ppo_pkg::PPO_OFF_MODE, 1'b1, 8'h00);
        i_tmr.fire(0, 16'h0001);
        @(negedge clk_i);
        check(pout_w, 16'h3C03);
        bus(ppo_pkg::PPO_OFF_NV_G3, 1'b1, 8'h5A);
        rd(ppo_pkg::PPO_OFF_NV_G3, 8'h5F);
        rd(ppo_pkg::PPO_OFF_NV_HIGH, 8'h5C);
        $display("t_stop end");
    endtask : t_stop
    task automatic test_done;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_trig();
        t_stop();
        test_done();
    end
endmodule : testbench
